// >>> include/sfr_page_regs.vh
`ifndef SFR_PAGE_REGS_VH
`define SFR_PAGE_REGS_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define SFR_ADDR_MAP_SELECT    8'h8F
`define SFR_ADDR_SYSTEM_CONTROL_PAGE_SELECT      8'hBF
`define SFR_SPACE_SIZE         256

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define MAP_SELECT_BIT         0
`define MAP_SELECT_RESET       8'h00
`define MAP_SELECT_RESET_BIT   1'b0
`define PAGE_SLOTS             4
`define SYSTEM_CONTROL_PAGE_SELECT_RESET         8'h00
`define PAGE_FIELD_MSB         2
`define PAGE_FIELD_LSB         0
`define PAGE_RSVD_BIT          3
`define PAGE_STORAGE_NUMBER_MSB               5
`define PAGE_STORAGE_NUMBER_LSB               4
`define OP_MSB                 7
`define OP_LSB                 6
`define OP_STORE               2'h2
`define OP_RESTORE             2'h3

`endif

// >>> design/page_field.v
`timescale 1ns/1ps
`include "sfr_page_regs.vh"

// ----------------------------------------
// one module page register, page field only
// ----------------------------------------
module page_field #(
	parameter PAGE_W = 3
) (
	input  wire              i_clk_sys,
	input  wire              i_arst_n,
	input  wire              i_wr,
	input  wire [PAGE_W-1:0] i_wdata,
	input  wire              i_hw_load,
	input  wire [PAGE_W-1:0] i_hw_data,
	output reg  [PAGE_W-1:0] o_page
);

	always @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_page <= {PAGE_W{1'b0}};
		end else if (i_hw_load) begin
			o_page <= i_hw_data;
		end else if (i_wr) begin
			o_page <= i_wdata;
		end
	end

endmodule // page_field

// >>> design/sfr_page_address_extension.v
// Overview of operation
// [R1] 256 directly addressed SFRs, paged beyond
// [R2] paged selection comes from page field
// [R3] core writes page before paged access
// [R4] each module sizes own pages, registers
// [R5] core sets map bit and valid page
// [R6] map bit at 8F bit0, both areas
// [R7] system control decoded only when map=0
// [R8] BF page register: page, reserved, write-only
// [R9] map, address, page pick one target
`timescale 1ns/1ps
`include "sfr_page_regs.vh"

module sfr_page_address_extension (
	input  wire       i_clk_sys,
	input  wire       i_arst_n,
	input  wire       i_sfr_wr,
	input  wire       i_sfr_rd,
	input  wire [7:0] i_sfr_addr,
	input  wire [7:0] i_sfr_wdata,
	input  wire [7:0] i_periph_rdata,
	output reg  [7:0] o_sfr_rdata,
	output reg        o_map_select_bit,
	output reg  [2:0] o_module_page,
	output reg        o_periph_sel,
	output reg  [7:0] o_periph_addr
);

	// ----------------------------------------
	// internal state and decode nets
	// ----------------------------------------
	localparam SLOTS = `PAGE_SLOTS;

	reg        map_sel;
	reg        next_map_sel;
	reg  [2:0] stored_page [0:SLOTS-1];
	reg  [7:0] next_rdata;
	reg  [7:0] next_sfr_rdata;
	reg        next_periph_sel;
	wire [2:0] page;
	wire       acc_any;
	wire       hit_map;
	wire       hit_page;
	wire       claimed;
	wire       map_wr;
	wire       page_wr;
	wire [1:0] op_field;
	wire [1:0] page_storage_number;
	wire [2:0] page_wdata;
	wire       do_store;
	wire       do_restore;
	wire [2:0] restore_page;
	integer    k;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	assign acc_any  = i_sfr_rd || i_sfr_wr;
	// map register answers in either area
	assign hit_map  = (i_sfr_addr == `SFR_ADDR_MAP_SELECT); // R6
	// page register only seen in the standard area
	assign hit_page = (i_sfr_addr == `SFR_ADDR_SYSTEM_CONTROL_PAGE_SELECT)
		&& !map_sel; // R7
	assign claimed  = hit_map || hit_page;
	assign map_wr   = i_sfr_wr && hit_map;
	assign page_wr  = i_sfr_wr && hit_page;

	// ----------------------------------------
	// page register write fields
	// ----------------------------------------
	assign op_field     = i_sfr_wdata[`OP_MSB:`OP_LSB];
	assign page_storage_number         = i_sfr_wdata[`PAGE_STORAGE_NUMBER_MSB:`PAGE_STORAGE_NUMBER_LSB];
	assign page_wdata   = i_sfr_wdata[`PAGE_FIELD_MSB:`PAGE_FIELD_LSB];
	assign do_store     = page_wr && (op_field == `OP_STORE);
	assign do_restore   = page_wr && (op_field == `OP_RESTORE);
	// storage number picks one of the slots
	assign restore_page = stored_page[page_storage_number];

	// ----------------------------------------
	// map-select register
	// ----------------------------------------
	always @* begin
		next_map_sel = map_sel;
		if (map_wr) begin
			next_map_sel = i_sfr_wdata[`MAP_SELECT_BIT]; // R6
		end
	end

	always @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			map_sel <= `MAP_SELECT_RESET_BIT; // R6
		end else begin
			map_sel <= next_map_sel;
		end
	end

	// ----------------------------------------
	// system control page field
	// ----------------------------------------
	// restore wins over the plain write of the same access
	page_field #(.PAGE_W(3)) u_page (
		.i_clk_sys (i_clk_sys),
		.i_arst_n  (i_arst_n),
		.i_wr      (page_wr),
		.i_wdata   (page_wdata),
		.i_hw_load (do_restore),
		.i_hw_data (restore_page),
		.o_page    (page)
	); // R2 R4 R8

	// ----------------------------------------
	// store slots for the page field
	// ----------------------------------------
	always @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (k = 0; k < SLOTS; k = k + 1) begin
				stored_page[k] <= 3'h0;
			end
		end else if (do_store) begin
			// slot takes the page from before this write
			stored_page[page_storage_number] <= page;
		end
	end

	// ----------------------------------------
	// read data select
	// ----------------------------------------
	always @* begin
		case (i_sfr_addr)
			`SFR_ADDR_MAP_SELECT: begin
				next_rdata = {7'h00, map_sel}; // R6
			end
			`SFR_ADDR_SYSTEM_CONTROL_PAGE_SELECT: begin
				if (map_sel) begin
					next_rdata = i_periph_rdata; // R7
				end else begin
					// op, storage number and reserved bit read zero
					next_rdata = {5'h00, page}; // R8
				end
			end
			default: begin
				next_rdata = i_periph_rdata; // R9
			end
		endcase
	end

	always @* begin
		next_sfr_rdata = 8'h00;
		if (i_sfr_rd) begin
			next_sfr_rdata = next_rdata;
		end
	end

	// ----------------------------------------
	// target select
	// ----------------------------------------
	// one target only: here or the paged peripherals
	always @* begin
		next_periph_sel = acc_any && !claimed; // R9
	end

	// ----------------------------------------
	// read data output
	// ----------------------------------------
	// held at zero between reads, no stale data
	always @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_sfr_rdata <= 8'h00;
		end else begin
			o_sfr_rdata <= next_sfr_rdata;
		end
	end

	// ----------------------------------------
	// map bit output
	// ----------------------------------------
	// lets paged modules follow the area select
	always @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_map_select_bit <= 1'b0;
		end else begin
			o_map_select_bit <= map_sel; // R1
		end
	end

	// ----------------------------------------
	// module page output
	// ----------------------------------------
	// paged modules pick their bank from this copy
	always @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_module_page <= 3'h0;
		end else begin
			o_module_page <= page; // R2
		end
	end

	// ----------------------------------------
	// target select output
	// ----------------------------------------
	// high for an access routed to the paged modules
	always @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_periph_sel <= 1'b0;
		end else begin
			o_periph_sel <= next_periph_sel; // R9
		end
	end

	// ----------------------------------------
	// address output
	// ----------------------------------------
	// full 256-entry address passed on
	always @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_periph_addr <= 8'h00;
		end else begin
			o_periph_addr <= i_sfr_addr; // R1
		end
	end

endmodule // sfr_page_address_extension

// >>> tb/sfr_page_asserts.sv
`timescale 1ns/1ps
module sfr_page_chk(input wire logic i_clk_sys,i_arst_n,i_sfr_wr,i_sfr_rd,
	o_map_select_bit,o_periph_sel,input wire logic [7:0] i_sfr_addr,
	i_sfr_wdata,i_periph_rdata,o_sfr_rdata,o_periph_addr,
	input wire logic [2:0] o_module_page);
default clocking @(posedge i_clk_sys); endclocking
default disable iff (!i_arst_n);
wire logic f8=i_sfr_addr==8'h8F;
wire logic fb=i_sfr_addr==8'hBF;
a_idle_zero: assert property(!i_sfr_rd |=> o_sfr_rdata==8'h00)
	else $error("rdata not zero");
a_map_read: assert property(i_sfr_rd&&f8 |=> !o_periph_sel&&
	o_sfr_rdata[7:1]==7'h00) else $error("map read");
a_page_rsvd: assert property(i_sfr_rd&&fb |=> o_periph_sel||
	o_sfr_rdata[7:3]==5'h00) else $error("page read");
a_periph_read: assert property(i_sfr_rd&&!f8&&!fb |=> o_periph_sel&&
	o_sfr_rdata==$past(i_periph_rdata)) else $error("periph read");
a_page_write: assert property(i_sfr_wr&&fb&&i_sfr_wdata[7:6]!=2'h3 |=>
	o_periph_sel or (##1 o_module_page==$past(i_sfr_wdata[2:0],2)))
	else $error("page write");
a_map_write: assert property(i_sfr_wr&&f8 |=> !o_periph_sel ##1
	o_map_select_bit==$past(i_sfr_wdata[0],2)) else $error("map write");
a_no_access: assert property(!(i_sfr_wr||i_sfr_rd) |=> !o_periph_sel)
	else $error("stray select");
a_addr_copy: assert property(i_sfr_wr||i_sfr_rd |=>
	o_periph_addr==$past(i_sfr_addr)) else $error("address copy");
cover property(i_sfr_wr&&fb);
cover property(o_periph_sel&&o_map_select_bit);
cover property(i_sfr_rd&&f8);
cover property(i_sfr_wr&&fb&&i_sfr_wdata[7:6]==2'h3);
endmodule // sfr_page_chk
bind sfr_page_address_extension sfr_page_chk u_chk(.*);

// >>> tb/core_model.sv
`timescale 1ns/1ps
module core_model(input wire logic i_clk_sys,output logic o_wr=0,o_rd=0,
	output logic [7:0] o_addr=8'h00,o_wd=8'h00);
task acc(input logic w,input logic [7:0] a,d);
	o_wr<=w;
	o_rd<=!w;
	o_addr<=a;
	o_wd<=d;
	@(posedge i_clk_sys) #1;
	o_wr<=0;
	o_rd<=0;
	o_addr<=~a;
	o_wd<=~d;
endtask
endmodule // core_model

// >>> tb/test_sfr_page_address_extension.sv
`timescale 1ns/1ps
module test_sfr_page_address_extension;
logic c=0,rn=0;
logic [7:0] p=8'h00,d;
logic [2:0] pm;
int bad_count=0,n_compared=0,cy=0;
wire w,r,m,s;
wire [7:0] a,wd,q,pa;
wire [2:0] pg;
always #4 c=~c;
core_model core(.i_clk_sys(c),.o_wr(w),.o_rd(r),.o_addr(a),.o_wd(wd));
sfr_page_address_extension dut(.i_clk_sys(c),.i_arst_n(rn),.i_sfr_wr(w),
	.i_sfr_rd(r),.i_sfr_addr(a),.i_sfr_wdata(wd),.i_periph_rdata(p),
	.o_sfr_rdata(q),.o_map_select_bit(m),.o_module_page(pg),
	.o_periph_sel(s),.o_periph_addr(pa));
task cmp(input string n,input logic [7:0] x,y);
	n_compared++;
	if (x!==y) begin
		bad_count++;
		$display("ERROR %s exp %h got %h",n,x,y);
	end
endtask
function logic [7:0] pv(input logic [7:0] v);
	return {5'h00,v[2:0]};
endfunction
task rdc(input logic [7:0] ad,x,input logic u);
	p=8'($urandom);
	core.acc(0,ad,8'h00);
	cmp("rdata",u?p:x,q);
	cmp("sel",{7'h00,u},{7'h00,s});
	@(posedge c) #1;
endtask
task wr(input logic [7:0] ad,dt);
	core.acc(1,ad,dt);
	@(posedge c) #1;
endtask
task print_verdict;
	$display("compared %0d bad %0d",n_compared,bad_count);
	if (bad_count==0&&n_compared>0) $display("Simulation passed");
	else $display("Simulation failed");
	$finish;
endtask
always @(posedge c) if (++cy>3000) begin
	bad_count++;
	print_verdict;
end
initial begin
	void'($urandom(32'h90128DEF));
	repeat(20) @(posedge c);
	#1 rn=1;
	rdc(8'h8F,8'h00,0);
	rdc(8'hBF,8'h00,0);
	repeat(8) begin
		d=8'($urandom)&8'h7F;
		pm=d[2:0];
		wr(8'hBF,d);
		cmp("page",pv(d),{5'h00,pg});
		rdc(8'hBF,pv(d),0);
	end
	wr(8'hBF,8'h95);
	cmp("page",8'h05,{5'h00,pg});
	wr(8'hBF,8'h02);
	wr(8'hBF,8'hD0);
	rdc(8'hBF,{5'h00,pm},0);
	wr(8'h8F,8'hFF);
	cmp("map",8'h01,{7'h00,m});
	rdc(8'h8F,8'h01,0);
	rdc(8'hBF,8'h00,1);
	wr(8'h8F,8'h00);
	repeat(6) rdc(8'($urandom)&8'hEE,8'h00,1);
	print_verdict;
end
endmodule // test_sfr_page_address_extension
